// ### hdl/pcmu_map.svh
// constants of the packed compare and multiply unit
// assumes opcodes arrive as the two-byte escape form with the escape byte first
`ifndef PCMU_MAP_SVH
`define PCMU_MAP_SVH
`define PCMU_OPC_WORD_EQ 16'h0f75
`define PCMU_OPC_BYTE_GT 16'h0f64
`define PCMU_OPC_DWORD_GT 16'h0f66
`define PCMU_OPC_WORD_GT 16'h0f65
`define PCMU_OPC_MADD 16'h0ff5
`define PCMU_OPC_MUL_HI 16'h0fe5
`define PCMU_OPC_MUL_LO 16'h0fd5
`define PCMU_MOD_REG 2'h3
`define PCMU_MOD_MSB 7
`define PCMU_MOD_LSB 6
`define PCMU_REG_MSB 5
`define PCMU_REG_LSB 3
`define PCMU_LAT_FAST 1
`define PCMU_LAT_MUL 2
`define PCMU_RESULT_RST 64'h0000_0000_0000_0000
`endif

// ### hdl/pcmu_pkg.sv
// types shared by the packed compare and multiply unit
// assumes nothing beyond a systemverilog compiler
package pcmu_pkg;
  typedef enum logic [2:0] {
    PCMU_OP_NONE = 3'b000,
    PCMU_OP_WORD_EQ = 3'b001,
    PCMU_OP_BYTE_GT = 3'b010,
    PCMU_OP_DWORD_GT = 3'b011,
    PCMU_OP_WORD_GT = 3'b100,
    PCMU_OP_MADD = 3'b101,
    PCMU_OP_MUL_HI = 3'b110,
    PCMU_OP_MUL_LO = 3'b111
  } pcmu_op_t;
  typedef logic [63:0] pcmu_vec_t;
  typedef logic [2:0] pcmu_idx_t;
endpackage

// ### hdl/pcmu_mul_if.sv
// carrier between the unit's issue logic and its multiply pipeline
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface pcmu_mul_if;
  import pcmu_pkg::*;
  logic issue;
  pcmu_op_t op;
  pcmu_vec_t a;
  pcmu_vec_t b;
  pcmu_idx_t idx;
  logic done;
  pcmu_vec_t result;
  pcmu_idx_t done_idx;
  modport issuer (output issue, output op, output a, output b, output idx,
    input done, input result, input done_idx);
  modport unit (input issue, input op, input a, input b, input idx,
    output done, output result, output done_idx);
endinterface

// ### hdl/pcmu_mul.sv
// two-stage signed word multiply pipeline: products, then selection or pair sum
// assumes the issuer presents one operation per cycle at most
`timescale 1ns/1ps
`include "pcmu_map.svh"
module pcmu_mul (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // issue and result carrier
  pcmu_mul_if.unit mul
);
  import pcmu_pkg::*;

  logic [31:0] prod [4];
  logic stage1_valid;
  pcmu_op_t stage1_op;
  pcmu_idx_t stage1_idx;
  logic done;
  pcmu_vec_t result;
  pcmu_idx_t done_idx;
  pcmu_vec_t next_result;
  wire [31:0] madd_lo = prod[0] + prod[1];
  wire [31:0] madd_hi = prod[2] + prod[3];
  // both pair sums side by side so every word lane selects in range
  wire [63:0] madd_all = {madd_hi, madd_lo};

  // stage one: four signed 16x16 products
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_prod
      wire signed [15:0] wa = mul.a[16*g +: 16];
      wire signed [15:0] wb = mul.b[16*g +: 16];
      wire signed [31:0] p = wa * wb;
      always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
          prod[g] <= 32'h0000_0000;
        end else if (mul.issue) begin
          prod[g] <= p;
        end
      end
      assign next_result[16*g +: 16] =
        (stage1_op == PCMU_OP_MUL_HI) ? prod[g][31:16] :
        (stage1_op == PCMU_OP_MUL_LO) ? prod[g][15:0] :
        madd_all[16*g +: 16];
    end
  endgenerate

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      stage1_valid <= 1'b0;
      stage1_op <= PCMU_OP_NONE;
      stage1_idx <= 3'h0;
    end else begin
      stage1_valid <= mul.issue;
      stage1_op <= mul.op;
      stage1_idx <= mul.idx;
    end
  end

  // stage two: one result per cycle, two cycles after issue
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      done <= 1'b0;
      result <= `PCMU_RESULT_RST;
      done_idx <= 3'h0;
    end else begin
      done <= stage1_valid;
      if (stage1_valid) begin
        result <= next_result;
        done_idx <= stage1_idx;
      end
    end
  end

  assign mul.done = done;
  assign mul.result = result;
  assign mul.done_idx = done_idx;

  sequence s_issue_op(pcmu_op_t o);
    mul.issue && mul.op == o;
  endsequence

  a_mul_two_clock: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    mul.issue |-> ##2 mul.done)
    else $error("multiply result not two cycles after issue");
  // operands widened first: a product at lane width would drop its upper half
  a_mul_upper_half: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    s_issue_op(PCMU_OP_MUL_HI) ##2 1'b1 |-> mul.result[31:16] ==
    16'((32'($signed($past(mul.a[31:16], 2))) * 32'($signed($past(mul.b[31:16], 2)))) >>> 16))
    else $error("upper product half wrong");
  a_mul_lower_half: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    s_issue_op(PCMU_OP_MUL_LO) ##2 1'b1 |-> mul.result[15:0] ==
    16'($past(mul.a[15:0], 2) * $past(mul.b[15:0], 2)))
    else $error("lower product half wrong");
  a_madd_pair_sum: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    s_issue_op(PCMU_OP_MADD) ##2 1'b1 |-> mul.result[63:32] ==
    32'(32'($signed($past(mul.a[47:32], 2))) * 32'($signed($past(mul.b[47:32], 2))) +
    32'($signed($past(mul.a[63:48], 2))) * 32'($signed($past(mul.b[63:48], 2)))))
    else $error("pair sum of products wrong");
  a_mul_no_spurious: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    mul.done |-> $past(mul.issue, 2))
    else $error("multiply result without an issue");
endmodule // pcmu_mul

// ### hdl/pcmu_top.sv
// packed compare and multiply execution unit of the core
// assumes decode presents opcode, mod/reg/rm byte and both operands in one cycle
//
// Summary of operation
// - word equal compare: lanes all ones or zero
// - byte greater compare: lanes all ones or zero
// - dword greater compare: lanes all ones or zero
// - word greater compare: lanes all ones or zero
// - multiply-add words into dwords, two clocks
// - multiply keeps upper product halves, two clocks
// - multiply keeps lower product halves, two clocks
// - mod 11 takes register, otherwise memory source
`timescale 1ns/1ps
`include "pcmu_map.svh"
module pcmu_top (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // issue from decode and operand fetch
  input wire logic issue_valid_in,
  input wire logic [15:0] opcode_in,
  input wire logic [7:0] modrm_in,
  input wire pcmu_pkg::pcmu_vec_t destination_vector_reg_in,
  input wire pcmu_pkg::pcmu_vec_t source_vector_reg_in,
  input wire pcmu_pkg::pcmu_vec_t memory_operand_in,
  // one-clock compare results
  output logic fast_valid_out,
  output pcmu_pkg::pcmu_vec_t fast_result_out,
  output pcmu_pkg::pcmu_idx_t fast_dest_out,
  // two-clock multiply results
  output logic mul_valid_out,
  output pcmu_pkg::pcmu_vec_t mul_result_out,
  output pcmu_pkg::pcmu_idx_t mul_dest_out,
  // opcode outside this group
  output logic unsupported_out
);
  import pcmu_pkg::*;

  function automatic pcmu_op_t decode_op(input logic [15:0] opc);
    case (opc)
      `PCMU_OPC_WORD_EQ: decode_op = PCMU_OP_WORD_EQ;
      `PCMU_OPC_BYTE_GT: decode_op = PCMU_OP_BYTE_GT;
      `PCMU_OPC_DWORD_GT: decode_op = PCMU_OP_DWORD_GT;
      `PCMU_OPC_WORD_GT: decode_op = PCMU_OP_WORD_GT;
      `PCMU_OPC_MADD: decode_op = PCMU_OP_MADD;
      `PCMU_OPC_MUL_HI: decode_op = PCMU_OP_MUL_HI;
      `PCMU_OPC_MUL_LO: decode_op = PCMU_OP_MUL_LO;
      default: decode_op = PCMU_OP_NONE;
    endcase
  endfunction

  pcmu_mul_if mul_bus ();

  wire pcmu_op_t op = decode_op(opcode_in);
  wire is_reg_form = modrm_in[`PCMU_MOD_MSB:`PCMU_MOD_LSB] == `PCMU_MOD_REG;
  // the register field names the destination in both forms
  wire pcmu_idx_t dest_idx = modrm_in[`PCMU_REG_MSB:`PCMU_REG_LSB];
  wire pcmu_vec_t src = is_reg_form ? source_vector_reg_in : memory_operand_in;
  wire pcmu_vec_t dst = destination_vector_reg_in;
  wire is_mul = op == PCMU_OP_MADD || op == PCMU_OP_MUL_HI || op == PCMU_OP_MUL_LO;
  wire is_fast = op == PCMU_OP_WORD_EQ || op == PCMU_OP_BYTE_GT ||
    op == PCMU_OP_DWORD_GT || op == PCMU_OP_WORD_GT;

  pcmu_vec_t packed_word_equal_compare;
  pcmu_vec_t packed_byte_greater_compare;
  pcmu_vec_t packed_dword_greater_compare;
  pcmu_vec_t packed_word_greater_compare;

  // lane compares; destination lane is the left operand of greater-than
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_byte
      assign packed_byte_greater_compare[8*g +: 8] =
        {8{$signed(dst[8*g +: 8]) > $signed(src[8*g +: 8])}};
    end
    for (g = 0; g < 4; g++) begin : g_word
      assign packed_word_equal_compare[16*g +: 16] =
        {16{dst[16*g +: 16] == src[16*g +: 16]}};
      assign packed_word_greater_compare[16*g +: 16] =
        {16{$signed(dst[16*g +: 16]) > $signed(src[16*g +: 16])}};
    end
    for (g = 0; g < 2; g++) begin : g_dword
      assign packed_dword_greater_compare[32*g +: 32] =
        {32{$signed(dst[32*g +: 32]) > $signed(src[32*g +: 32])}};
    end
  endgenerate

  pcmu_vec_t next_fast_result;
  always_comb begin
    case (op)
      PCMU_OP_WORD_EQ: next_fast_result = packed_word_equal_compare;
      PCMU_OP_BYTE_GT: next_fast_result = packed_byte_greater_compare;
      PCMU_OP_DWORD_GT: next_fast_result = packed_dword_greater_compare;
      PCMU_OP_WORD_GT: next_fast_result = packed_word_greater_compare;
      default: next_fast_result = `PCMU_RESULT_RST;
    endcase
  end

  // one compare per clock, result in the following cycle
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      fast_valid_out <= 1'b0;
      unsupported_out <= 1'b0;
    end else begin
      fast_valid_out <= issue_valid_in && is_fast;
      unsupported_out <= issue_valid_in && op == PCMU_OP_NONE;
    end
  end

  // data held between results so the writeback port stays quiet
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      fast_result_out <= `PCMU_RESULT_RST;
      fast_dest_out <= 3'h0;
    end else if (issue_valid_in && is_fast) begin
      fast_result_out <= next_fast_result;
      fast_dest_out <= dest_idx;
    end
  end

  // multiplies go to their own port: a compare issued right after one
  // would otherwise collide with it at writeback
  assign mul_bus.issue = issue_valid_in && is_mul;
  assign mul_bus.op = op;
  assign mul_bus.a = dst;
  assign mul_bus.b = src;
  assign mul_bus.idx = dest_idx;

  pcmu_mul u_mul (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .mul(mul_bus.unit)
  );

  // these come straight from the pipeline's last flip-flops
  assign mul_valid_out = mul_bus.done;
  assign mul_result_out = mul_bus.result;
  assign mul_dest_out = mul_bus.done_idx;

  sequence s_fast_issue(pcmu_op_t o);
    issue_valid_in && op == o;
  endsequence

  // an issue seen while reset is low is never taken, so it must not count
  a_fast_one_clock: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    fast_valid_out == $past(issue_valid_in && is_fast && rstn_in))
    else $error("compare result not one cycle after issue");
  a_mul_port_timing: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    mul_valid_out == ($past(issue_valid_in && is_mul && rstn_in, 2) && $past(rstn_in)))
    else $error("multiply result not two cycles after issue");
  a_unsupported_pulse: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    unsupported_out == $past(issue_valid_in && op == PCMU_OP_NONE && rstn_in))
    else $error("unsupported flag not one cycle after issue");
  a_reset_clears: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    $rose(rstn_in) |-> !fast_valid_out && !mul_valid_out && !unsupported_out &&
    fast_result_out == `PCMU_RESULT_RST && mul_result_out == `PCMU_RESULT_RST)
    else $error("outputs not cleared by reset");
  // writeback ports hold their data between results
  a_fast_result_hold: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    $past(rstn_in && !(issue_valid_in && is_fast)) |->
    $stable(fast_result_out) && $stable(fast_dest_out))
    else $error("compare result changed without a compare");
  a_mul_result_hold: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    $past(rstn_in) && !$past(issue_valid_in && is_mul, 2) |->
    $stable(mul_result_out) && $stable(mul_dest_out))
    else $error("multiply result changed without a multiply");
  a_word_equal_lane: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    s_fast_issue(PCMU_OP_WORD_EQ) |=> fast_result_out[31:16] ==
    {16{$past(dst[31:16]) == $past(src[31:16])}})
    else $error("word equal lane wrong");
  a_word_equal_high: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    s_fast_issue(PCMU_OP_WORD_EQ) |=> fast_result_out[63:48] ==
    {16{$past(dst[63:48]) == $past(src[63:48])}})
    else $error("word equal upper lane wrong");
  a_byte_greater_lane: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    s_fast_issue(PCMU_OP_BYTE_GT) |=> fast_result_out[63:56] ==
    {8{$signed($past(dst[63:56])) > $signed($past(src[63:56]))}})
    else $error("byte greater lane wrong");
  a_byte_greater_low: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    s_fast_issue(PCMU_OP_BYTE_GT) |=> fast_result_out[7:0] ==
    {8{$signed($past(dst[7:0])) > $signed($past(src[7:0]))}})
    else $error("byte greater low lane wrong");
  a_dword_greater_lane: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    s_fast_issue(PCMU_OP_DWORD_GT) |=> fast_result_out[31:0] ==
    {32{$signed($past(dst[31:0])) > $signed($past(src[31:0]))}})
    else $error("dword greater lane wrong");
  a_dword_greater_high: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    s_fast_issue(PCMU_OP_DWORD_GT) |=> fast_result_out[63:32] ==
    {32{$signed($past(dst[63:32])) > $signed($past(src[63:32]))}})
    else $error("dword greater upper lane wrong");
  a_word_greater_sign: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    s_fast_issue(PCMU_OP_WORD_GT) ##0 (dst[31] == 1'b0 && src[31] == 1'b1) |=>
    fast_result_out[31:16] == 16'hffff)
    else $error("signed word greater compare wrong");
  a_word_greater_lane: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    s_fast_issue(PCMU_OP_WORD_GT) |=> fast_result_out[63:48] ==
    {16{$signed($past(dst[63:48])) > $signed($past(src[63:48]))}})
    else $error("word greater upper lane wrong");
  a_memory_form: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    s_fast_issue(PCMU_OP_WORD_EQ) ##0 !is_reg_form |=> fast_result_out[15:0] ==
    {16{$past(dst[15:0]) == $past(memory_operand_in[15:0])}})
    else $error("memory source form not used");
  a_fast_dest_field: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    issue_valid_in && is_fast |=> fast_dest_out == $past(modrm_in[5:3]))
    else $error("compare destination index wrong");
  a_dest_field: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    issue_valid_in && is_mul |-> ##2 mul_dest_out == $past(modrm_in[5:3], 2))
    else $error("multiply destination index wrong");
endmodule // pcmu_top

// ### verification/pcmu_decode_model.sv
// decode and operand fetch stand-in feeding the packed compare and multiply unit
// assumes the bench calls issue and idle in order, one call per clock
`timescale 1ns/1ps
module pcmu_decode_model (
  // clock
  input wire logic core_clk_in,
  // issue toward the unit
  output logic issue_valid_out,
  output logic [15:0] opcode_out,
  output logic [7:0] modrm_out,
  output pcmu_pkg::pcmu_vec_t dest_out,
  output pcmu_pkg::pcmu_vec_t src_out,
  output pcmu_pkg::pcmu_vec_t mem_out
);
  import pcmu_pkg::*;
  initial begin
    issue_valid_out = 1'b0;
    opcode_out = 16'h0000;
    modrm_out = 8'h00;
    dest_out = 64'h0;
    src_out = 64'h0;
    mem_out = 64'h0;
  end
  task automatic issue(input logic [15:0] opc, input logic [7:0] mrm, input pcmu_vec_t d,
      input pcmu_vec_t s, input pcmu_vec_t m);
    @(posedge core_clk_in);
    #1;
    issue_valid_out = 1'b1;
    opcode_out = opc;
    modrm_out = mrm;
    dest_out = d;
    src_out = s;
    mem_out = m;
  endtask
  // no live request: fields flip so a stale operand is never mistaken for a good one
  task automatic idle();
    @(posedge core_clk_in);
    #1;
    issue_valid_out = 1'b0;
    opcode_out = ~opcode_out;
    modrm_out = ~modrm_out;
    dest_out = ~dest_out;
    src_out = ~src_out;
    mem_out = ~mem_out;
  endtask
endmodule // pcmu_decode_model

// ### verification/tb.sv
// self-checking bench for the packed compare and multiply unit
// assumes the decode model drives issues one cycle apart, 1 ns after the edge
`timescale 1ns/1ps
`include "pcmu_map.svh"
module tb;
  import pcmu_pkg::*;
  typedef struct {logic [15:0] opc; logic [7:0] mrm; pcmu_vec_t d, s, m, r;} pcmu_row_t;
  typedef struct packed {logic f; logic x; logic u; pcmu_vec_t r; pcmu_idx_t dst;} pcmu_exp_t;
  logic core_clk_in, rstn_in, issue_valid_in;
  logic [15:0] opcode_in;
  logic [7:0] modrm_in;
  pcmu_vec_t dst_v, src_v, mem_v, fast_r, mul_r;
  logic fast_v, mul_v, unsup;
  pcmu_idx_t fast_d, mul_d;
  pcmu_row_t rows [7];
  pcmu_exp_t p1 = '0;
  pcmu_exp_t p2 = '0;
  int miscompares = 0;
  int comparisons = 0;
  pcmu_decode_model fe (.core_clk_in(core_clk_in), .issue_valid_out(issue_valid_in),
    .opcode_out(opcode_in), .modrm_out(modrm_in), .dest_out(dst_v), .src_out(src_v),
    .mem_out(mem_v));
  pcmu_top dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .issue_valid_in(issue_valid_in),
    .opcode_in(opcode_in), .modrm_in(modrm_in), .destination_vector_reg_in(dst_v),
    .source_vector_reg_in(src_v), .memory_operand_in(mem_v), .fast_valid_out(fast_v),
    .fast_result_out(fast_r), .fast_dest_out(fast_d), .mul_valid_out(mul_v),
    .mul_result_out(mul_r), .mul_dest_out(mul_d), .unsupported_out(unsup));
  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    comparisons++;
    if (seen !== want) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask
  function automatic pcmu_vec_t exp_res(input logic [15:0] opc, input pcmu_vec_t d,
      input pcmu_vec_t s);
    logic signed [31:0] p;
    pcmu_vec_t r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      if (opc == `PCMU_OPC_BYTE_GT) r[8*i+:8] = {8{$signed(d[8*i+:8]) > $signed(s[8*i+:8])}};
    end
    for (int i = 0; i < 4; i++) begin
      p = $signed(d[16*i+:16]) * $signed(s[16*i+:16]);
      case (opc)
        `PCMU_OPC_WORD_EQ: r[16*i+:16] = {16{d[16*i+:16] == s[16*i+:16]}};
        `PCMU_OPC_WORD_GT: r[16*i+:16] = {16{$signed(d[16*i+:16]) > $signed(s[16*i+:16])}};
        `PCMU_OPC_MUL_HI: r[16*i+:16] = p[31:16];
        `PCMU_OPC_MUL_LO: r[16*i+:16] = p[15:0];
        default: ;
      endcase
    end
    for (int j = 0; j < 2; j++) begin
      if (opc == `PCMU_OPC_DWORD_GT)
        r[32*j+:32] = {32{$signed(d[32*j+:32]) > $signed(s[32*j+:32])}};
      if (opc == `PCMU_OPC_MADD) r[32*j+:32] = $signed(d[32*j+:16]) * $signed(s[32*j+:16])
        + $signed(d[32*j+16+:16]) * $signed(s[32*j+16+:16]);
    end
    return r;
  endfunction
  // scoreboard: every taken issue is expected one or two edges later
  always @(posedge core_clk_in) begin : sb_take
    pcmu_exp_t e;
    e = '0;
    if (rstn_in && issue_valid_in) begin
      e.f = opcode_in inside {16'h0f75, 16'h0f64, 16'h0f66, 16'h0f65};
      e.x = opcode_in inside {16'h0ff5, 16'h0fe5, 16'h0fd5};
      e.u = !(e.f || e.x);
      e.r = exp_res(opcode_in, dst_v, modrm_in[7:6] == `PCMU_MOD_REG ? src_v : mem_v);
      e.dst = modrm_in[5:3];
    end
    p2 <= rstn_in ? p1 : '0;
    p1 <= e;
  end
  always @(negedge core_clk_in) begin
    chk(64'(fast_v), 64'(p1.f));
    chk(64'(mul_v), 64'(p2.x));
    chk(64'(unsup), 64'(p1.u));
    if (p1.f) chk(fast_r, p1.r);
    if (p1.f) chk(64'(fast_d), 64'(p1.dst));
    if (p2.x) chk(mul_r, p2.r);
    if (p2.x) chk(64'(mul_d), 64'(p2.dst));
  end
  task automatic send(input int i);
    fe.issue(rows[i].opc, rows[i].mrm, rows[i].d, rows[i].s, rows[i].m);
  endtask
  task automatic close_out();
    $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end
  initial begin
    repeat (2000) @(posedge core_clk_in);
    miscompares++;
    close_out();
  end
  initial begin
    rstn_in = 1'b0;
    rows[0] = '{16'h0f75, 8'hc8, 64'h1234_0000_ffff_8000, 64'h1234_0001_ffff_7fff, 64'h0,
      64'hffff_0000_ffff_0000};
    rows[1] = '{16'h0f64, 8'h10, 64'h807f_0100_ff05_1000, 64'h0, 64'h7f80_0001_0005_0f00,
      64'h00ff_ff00_0000_ff00};
    rows[2] = '{16'h0f66, 8'hda, 64'h0000_0001_8000_0000, 64'hffff_ffff_7fff_ffff, 64'h0,
      64'hffff_ffff_0000_0000};
    rows[3] = '{16'h0f65, 8'h64, 64'h0001_8000_7fff_ffff, 64'h0, 64'h0000_7fff_8000_0000,
      64'hffff_0000_ffff_0000};
    rows[4] = '{16'h0ff5, 8'hed, 64'h8000_8000_0002_ffff, 64'h8000_8000_0003_0004, 64'h0,
      64'h8000_0000_0000_0002};
    rows[5] = '{16'h0fe5, 8'hb6, 64'h7fff_ffff_8000_0100, 64'h0, 64'h7fff_0002_8000_0100,
      64'h3fff_ffff_4000_0001};
    rows[6] = '{16'h0fd5, 8'hff, 64'h7fff_ffff_8000_0100, 64'h7fff_0002_8000_0100, 64'h0,
      64'h0001_fffe_0000_0000};
    repeat (3) @(posedge core_clk_in);
    #1;
    rstn_in = 1'b1;
    chk(fast_r | mul_r, `PCMU_RESULT_RST);
    // one at a time, fixed latency per kind of instruction
    for (int i = 0; i < 7; i++) begin
      send(i);
      fe.idle();
      if (i >= 4) @(posedge core_clk_in);
      if (i >= 4) #1;
      if (i < 4) chk(fast_r, rows[i].r);
      else chk(mul_r, rows[i].r);
    end
    // back to back, including neighbours of the group's opcodes
    for (int i = 6; i >= 0; i--) send(i);
    fe.issue(16'h0f74, 8'hc0, 64'h0, 64'h0, 64'h0);
    send(4);
    fe.issue(16'h0f00, 8'h00, 64'h0, 64'h0, 64'h0);
    // word equal through the memory form; the register source deliberately differs
    fe.issue(16'h0f75, 8'h05, 64'h8000_0000_1234_5678, 64'h0,
      64'h8000_0001_0000_5678);
    send(0);
    fe.idle();
    repeat (3) @(posedge core_clk_in);
    // reset lands while a multiply-add is in flight
    send(4);
    fe.idle();
    rstn_in = 1'b0;
    repeat (2) @(posedge core_clk_in);
    #1;
    rstn_in = 1'b1;
    chk(fast_r | mul_r, `PCMU_RESULT_RST);
    send(5);
    send(1);
    fe.idle();
    repeat (3) @(posedge core_clk_in);
    close_out();
  end
endmodule // tb
